// [verilog/ccr_pkg.sv]
// Constants for the CPU control register block: memory map, status word layout,
// reset values and the bus register map. Assumes a 16-bit address CPU.
package ccr_pkg;
    // Program memory map
    localparam logic [15:0] VEC_BASE = 16'h0000;
    localparam logic [15:0] VEC_LAST = 16'h003F;
    localparam logic [15:0] TCALL_BASE = 16'h0040;
    localparam logic [15:0] TCALL_LAST = 16'h007F;
    localparam logic [15:0] OPT_BASE = 16'h0080;
    localparam logic [15:0] OPT_LAST = 16'h0084;
    localparam logic [15:0] DBGID_BASE = 16'h0085;
    localparam logic [15:0] DBGID_LAST = 16'h008E;
    localparam logic [15:0] SWAP_OFFSET = 16'h1000;
    localparam logic [15:0] FCALL_BASE = 16'h0800;
    localparam logic [15:0] FCALL_LAST = 16'h0FFF;
    // Data memory map
    localparam logic [15:0] BANK_BASE = 16'hFEE0;
    localparam logic [15:0] BANK_LAST = 16'hFEFF;
    localparam logic [15:0] SFR_BASE = 16'hFF00;
    localparam logic [15:0] SFR_LAST = 16'hFFFF;
    localparam logic [15:0] HSRAM_BASE = 16'hFB00;
    // Status word bit positions
    localparam int PSW_CY = 0;
    localparam int PSW_ISP = 1;
    localparam int PSW_BANK_SELECT_BIT_LOW = 3;
    localparam int PSW_AC = 4;
    localparam int PSW_BANK_SELECT_BIT_HIGH = 5;
    localparam int PSW_Z = 6;
    localparam int PSW_IE = 7;
    localparam logic [7:0] PSW_RESET = 8'h02;
    localparam logic [15:0] SP_RESET = 16'hFEE0;
    localparam logic [4:0] BRK_SLOT = 5'h1F;
    localparam logic [1:0] RP_AX = 2'h0;
    // Bus register byte addresses
    localparam logic [5:0] REG_PC = 6'h00;
    localparam logic [5:0] REG_PSW = 6'h04;
    localparam logic [5:0] REG_SP = 6'h08;
    localparam logic [5:0] REG_CTRL = 6'h0C;
    localparam logic [5:0] REG_STAT = 6'h10;
    localparam logic [5:0] REG_GPR = 6'h20;
    localparam logic [5:0] REG_MAP = 6'h14;
    localparam logic [31:0] UNMAPPED = 32'hDEAD_0000;
    // Operation codes for the core port
    typedef enum logic [3:0] {
        CCR_OP_NONE = 4'h0,
        CCR_OP_STEP = 4'h1,
        CCR_OP_BRANCH = 4'h2,
        CCR_OP_TCALL = 4'h3,
        CCR_OP_FCALL = 4'h4,
        CCR_OP_INTACK = 4'h5,
        CCR_OP_BRK = 4'h6,
        CCR_OP_INTERRUPT_RETURN_INSTR = 4'h7,
        CCR_OP_PUSHPSW = 4'h8,
        CCR_OP_POPPSW = 4'h9,
        CCR_OP_DI = 4'hA,
        CCR_OP_EI = 4'hB,
        CCR_OP_SELRB = 4'hC,
        CCR_OP_ALU = 4'hD,
        CCR_OP_POPRP = 4'hE,
        CCR_OP_PUSHRP = 4'hF
    } ccr_op_type;
    typedef enum logic [1:0] {
        CCR_IDLE = 2'b00,
        CCR_VEC_LO = 2'b01,
        CCR_VEC_HI = 2'b10,
        CCR_VEC_LD = 2'b11
    } ccr_state_type;
endpackage

// [verilog/ccr_regs.sv]
// CPU control registers, register banks and memory-map decode.
// Assumes a core driving one operation per cycle and a program memory
// read port with one cycle latency; software reaches state over Avalon-MM.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
module ccr_regs
    import ccr_pkg::*;
#(
    parameter int NUM_SRC = 29
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire ccr_pkg::ccr_op_type op,
    input wire logic [2:0] op_len,
    input wire logic [15:0] op_target,
    input wire logic [4:0] op_src,
    input wire logic [1:0] op_bank,
    input wire logic [7:0] alu_result,
    input wire logic alu_carry,
    input wire logic alu_half_carry,
    input wire logic [1:0] alu_flag_mask,
    input wire logic alu_carry_we,
    input wire logic [7:0] stack_rdata,
    input wire logic [NUM_SRC-1:0] irq_req,
    input wire logic [NUM_SRC-1:0] irq_low_prio,
    output logic irq_take,
    output logic [4:0] irq_sel,
    input wire logic [2:0] gpr_addr,
    input wire logic gpr_we,
    input wire logic [7:0] gpr_wdata,
    input wire logic gpr_pair,
    input wire logic [15:0] gpr_wdata16,
    output logic [15:0] gpr_rdata,
    input wire logic [15:0] data_addr,
    output logic data_is_bank,
    output logic data_is_sfr,
    output logic data_stack_ok,
    output logic fetch_fault,
    output logic [15:0] pmem_addr,
    input wire logic [7:0] pmem_rdata,
    output logic [15:0] program_counter,
    output logic [7:0] program_status_word,
    output logic [15:0] stack_pointer,
    output logic stack_we,
    output logic [7:0] stack_wdata,
    output logic [15:0] stack_addr,
    output logic boot_ready
);
    import ccr_pkg::*;

    initial begin
        // Source slots must stay below the break slot
        if (NUM_SRC < 1 || NUM_SRC > 29) begin
            $error("NUM_SRC out of range");
        end
    end

    ccr_state_type state;
    logic boot_swap;
    logic [7:0] vec_lo;
    logic [15:0] vec_addr;
    logic rd_done;
    logic [7:0] bank_mem [0:31];
    logic [4:0] gpr_idx;
    logic [4:0] pick;
    logic found;
    logic [7:0] stat_bits;

    // Register bank index from bank-select bits
    // bank selection
    assign gpr_idx = {program_status_word[PSW_BANK_SELECT_BIT_HIGH], program_status_word[PSW_BANK_SELECT_BIT_LOW], gpr_addr};

    assign gpr_rdata = gpr_pair ? {bank_mem[{gpr_idx[4:1], 1'b1}], bank_mem[{gpr_idx[4:1], 1'b0}]}
                                : {8'h00, bank_mem[gpr_idx]};

    assign data_is_bank = (data_addr >= BANK_BASE) && (data_addr <= BANK_LAST);
    assign data_is_sfr = data_addr >= SFR_BASE;
    assign data_stack_ok = (data_addr >= HSRAM_BASE) && (data_addr <= BANK_LAST);
    assign fetch_fault = (program_counter >= BANK_BASE) && (program_counter <= BANK_LAST);

    always_comb begin
        pick = 5'h00;
        found = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (irq_req[i] && (program_status_word[PSW_ISP] || !irq_low_prio[i])) begin
                pick = 5'(i);
                found = 1'b1;
            end
        end
    end
    assign irq_take = found && program_status_word[PSW_IE] && state == CCR_IDLE;
    assign irq_sel = pick;

    always_comb begin
        case (state)
            CCR_VEC_LO: pmem_addr = vec_addr;
            CCR_VEC_HI: pmem_addr = vec_addr | 16'h0001;
            default: pmem_addr = program_counter;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= CCR_VEC_LO;
            vec_lo <= 8'h00;
            vec_addr <= VEC_BASE;
        end else begin
            case (state)
                CCR_IDLE: begin
                    // acknowledge and break fetch their own entry
                    if (irq_take) begin
                        vec_addr <= VEC_BASE + {10'h000, pick + 5'h02, 1'b0};
                        state <= CCR_VEC_LO;
                    end else if (op == CCR_OP_BRK) begin
                        vec_addr <= VEC_BASE + {10'h000, BRK_SLOT, 1'b0};
                        state <= CCR_VEC_LO;
                    end
                end
                CCR_VEC_LO: begin
                    state <= CCR_VEC_HI;
                end
                // Memory answers one cycle late, so each byte lands a state later
                CCR_VEC_HI: begin
                    vec_lo <= pmem_rdata;
                    state <= CCR_VEC_LD;
                end
                CCR_VEC_LD: begin
                    state <= CCR_IDLE;
                end
                default: state <= CCR_IDLE;
            endcase
        end
    end
    assign boot_ready = state == CCR_IDLE;

    logic [15:0] next_pc;
    always_comb begin
        next_pc = program_counter;
        case (op)
            CCR_OP_STEP: next_pc = program_counter + 16'(op_len);
            CCR_OP_BRANCH: next_pc = op_target;
            CCR_OP_INTERRUPT_RETURN_INSTR: next_pc = op_target;
            CCR_OP_TCALL: next_pc = TCALL_BASE | {10'h000, op_target[4:0], 1'b0};
            CCR_OP_FCALL: next_pc = FCALL_BASE | (op_target & (FCALL_LAST ^ FCALL_BASE));
            CCR_OP_BRK: next_pc = {10'h000, BRK_SLOT, 1'b0};
            default: next_pc = program_counter;
        endcase
        if (irq_take) begin
            next_pc = VEC_BASE + {10'h000, pick + 5'h02, 1'b0};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            program_counter <= VEC_BASE;
        end else if (state == CCR_VEC_LD) begin
            program_counter <= {pmem_rdata, vec_lo};
        end else if (avs_write && avs_address == REG_PC) begin
            program_counter <= avs_writedata[15:0];
        end else if (state == CCR_IDLE) begin
            program_counter <= next_pc;
        end
    end

    logic [7:0] next_psw;
    always_comb begin
        next_psw = program_status_word;
        case (op)
            CCR_OP_DI: next_psw[PSW_IE] = 1'b0;
            CCR_OP_EI: next_psw[PSW_IE] = 1'b1;
            CCR_OP_BRK: next_psw[PSW_IE] = 1'b0;
            CCR_OP_SELRB: begin
                next_psw[PSW_BANK_SELECT_BIT_LOW] = op_bank[0];
                next_psw[PSW_BANK_SELECT_BIT_HIGH] = op_bank[1];
            end
            CCR_OP_INTERRUPT_RETURN_INSTR: next_psw = stack_rdata;
            CCR_OP_POPPSW: next_psw = stack_rdata;
            CCR_OP_ALU: begin
                if (alu_flag_mask[0]) begin
                    next_psw[PSW_Z] = alu_result == 8'h00;
                end
                if (alu_flag_mask[1]) begin
                    next_psw[PSW_AC] = alu_half_carry;
                end
            end
            default: next_psw = program_status_word;
        endcase
        if (alu_carry_we) begin
            next_psw[PSW_CY] = alu_carry;
        end
        if (irq_take) begin
            next_psw[PSW_IE] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            program_status_word <= PSW_RESET;
        end else if (avs_write && avs_address == REG_PSW && avs_byteenable[0]) begin
            program_status_word <= avs_writedata[7:0];
        end else if (state == CCR_IDLE) begin
            program_status_word <= next_psw;
        end
    end

    // Push of status word happens on the cycle the pointer drops
    logic psw_push;
    assign psw_push = irq_take || op == CCR_OP_PUSHPSW || op == CCR_OP_BRK;
    assign stack_we = state == CCR_IDLE && (psw_push || op == CCR_OP_PUSHRP);
    assign stack_wdata = psw_push ? program_status_word : gpr_rdata[7:0];
    assign stack_addr = stack_we ? stack_pointer - 16'h0001 : stack_pointer;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stack_pointer <= SP_RESET;
        end else if (avs_write && avs_address == REG_SP) begin
            stack_pointer <= avs_writedata[15:0];
        end else if (stack_we) begin
            stack_pointer <= stack_pointer - 16'h0001;
        end else if (state == CCR_IDLE && (op == CCR_OP_INTERRUPT_RETURN_INSTR || op == CCR_OP_POPPSW
                                          || op == CCR_OP_POPRP)) begin
            stack_pointer <= stack_pointer + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (gpr_we) begin
            if (gpr_pair) begin
                bank_mem[{gpr_idx[4:1], 1'b0}] <= gpr_wdata16[7:0];
                bank_mem[{gpr_idx[4:1], 1'b1}] <= gpr_wdata16[15:8];
            end else begin
                bank_mem[gpr_idx] <= gpr_wdata;
            end
        end
    end

    // Boot swap selects which copy of options and debug ID is used
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_swap <= 1'b0;
        end else if (avs_write && avs_address == REG_CTRL && avs_byteenable[0]) begin
            boot_swap <= avs_writedata[0];
        end
    end

    logic [15:0] opt_addr;
    assign opt_addr = boot_swap ? OPT_BASE + SWAP_OFFSET : OPT_BASE;
    logic [15:0] dbg_addr;
    assign dbg_addr = boot_swap ? DBGID_BASE + SWAP_OFFSET : DBGID_BASE;

    assign stat_bits = {5'h00, fetch_fault, found, boot_ready};
    // Reads take one wait state so registered read data stands at the accepting edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_done <= 1'b0;
        end else begin
            rd_done <= avs_read && !rd_done;
        end
    end
    assign avs_waitrequest = avs_read && !rd_done;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !rd_done) begin
            case (avs_address)
                REG_PC: avs_readdata <= {16'h0000, program_counter};
                REG_PSW: avs_readdata <= {24'h000000, program_status_word};
                REG_SP: avs_readdata <= {16'h0000, stack_pointer};
                REG_CTRL: avs_readdata <= {31'h0, boot_swap};
                REG_STAT: avs_readdata <= {24'h000000, stat_bits};
                REG_MAP: avs_readdata <= {opt_addr, dbg_addr};
                default: avs_readdata <= UNMAPPED;
            endcase
        end
    end
endmodule

// [testbench/ccr_regs_chk.sv]
// Concurrent checks on the CPU control register block ports.
// Assumes it is bound to ccr_regs and sees only its ports, one clock domain.
module ccr_regs_chk
    import ccr_pkg::*;
#(
    parameter int NUM_SRC = 29
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic avs_write,
    input wire ccr_pkg::ccr_op_type op,
    input wire logic [2:0] op_len,
    input wire logic [15:0] op_target,
    input wire logic [1:0] op_bank,
    input wire logic [NUM_SRC-1:0] irq_low_prio,
    input wire logic irq_take,
    input wire logic [4:0] irq_sel,
    input wire logic [15:0] data_addr,
    input wire logic data_is_bank,
    input wire logic data_is_sfr,
    input wire logic [15:0] program_counter,
    input wire logic [7:0] program_status_word,
    input wire logic [15:0] stack_pointer,
    input wire logic stack_we,
    input wire logic [15:0] stack_addr,
    input wire logic [7:0] stack_wdata,
    input wire logic boot_ready
);
    // Core ops are judged only when no bus write or acknowledge competes
    wire logic go = boot_ready && !avs_write && !irq_take;
    // Vector fetches after interrupts also raise boot_ready; only the first counts
    logic booted;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            booted <= 1'b0;
        end else if (boot_ready) begin
            booted <= 1'b1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    psw_reset_a:
        assert property ($rose(boot_ready) && !booted |-> program_status_word == PSW_RESET)
        else $error("status word wrong at boot");
    pc_step_a:
        assert property (go && op == CCR_OP_STEP |=>
            program_counter == $past(program_counter) + {13'h0, $past(op_len)})
        else $error("program counter did not advance by length");
    pc_branch_a:
        assert property (go && op == CCR_OP_BRANCH |=> program_counter == $past(op_target))
        else $error("program counter not loaded on branch");
    di_clear_a:
        assert property (go && op == CCR_OP_DI |=> !program_status_word[PSW_IE])
        else $error("enable flag not cleared by mask");
    ack_ie_a:
        assert property (irq_take && !avs_write |->
            program_status_word[PSW_IE] ##1 !program_status_word[PSW_IE])
        else $error("acknowledge without enable or enable kept");
    low_prio_a:
        assert property (irq_take && irq_low_prio[irq_sel] |-> program_status_word[PSW_ISP])
        else $error("low priority taken while priority flag clear");
    bank_sel_a:
        assert property (go && op == CCR_OP_SELRB |=>
            {program_status_word[PSW_BANK_SELECT_BIT_HIGH], program_status_word[PSW_BANK_SELECT_BIT_LOW]} == $past(op_bank))
        else $error("bank select field wrong");
    bank_map_a:
        assert property (data_is_bank == (data_addr >= BANK_BASE && data_addr <= BANK_LAST))
        else $error("bank decode wrong");
    sfr_map_a:
        assert property (data_is_sfr == (data_addr >= SFR_BASE))
        else $error("peripheral decode wrong");
    push_psw_a:
        assert property (go && op == CCR_OP_PUSHPSW |-> (stack_we && stack_addr ==
            stack_pointer - 16'h1 && stack_wdata == program_status_word) ##1
            (stack_pointer == $past(stack_pointer) - 16'h1))
        else $error("status push wrong");
    cover property ($rose(boot_ready));
    cover property (irq_take);
    cover property (go && op == CCR_OP_PUSHPSW);
endmodule

bind ccr_regs ccr_regs_chk #(.NUM_SRC(NUM_SRC)) ccr_regs_chk_i (
    .clk, .arst_n, .avs_write, .op, .op_len, .op_target, .op_bank, .irq_low_prio,
    .irq_take, .irq_sel, .data_addr, .data_is_bank, .data_is_sfr, .program_counter,
    .program_status_word, .stack_pointer, .stack_we, .stack_addr, .stack_wdata, .boot_ready
);

// [testbench/ccr_regs_test.sv]
// Self-checking bench for the CPU control register block.
// Assumes ccr_regs with Avalon-MM access and a one-cycle program memory.
module ccr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;
    localparam int NSRC = 29;
    logic clk, arst_n, avs_read, avs_write, avs_waitrequest, irq_take, boot_ready;
    logic alu_carry, alu_half_carry, alu_carry_we, gpr_we, gpr_pair, stack_we;
    logic data_is_bank, data_is_sfr, data_stack_ok, fetch_fault;
    logic [5:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    ccr_op_type op;
    logic [2:0] op_len, gpr_addr;
    logic [15:0] op_target, gpr_wdata16, gpr_rdata, data_addr, pmem_addr;
    logic [15:0] program_counter, stack_pointer, stack_addr;
    logic [4:0] op_src, irq_sel, seen_sel;
    logic [1:0] op_bank, alu_flag_mask;
    logic [7:0] alu_result, stack_rdata, gpr_wdata, pmem_rdata, program_status_word, stack_wdata;
    logic [NSRC-1:0] irq_req, irq_low_prio;
    logic [15:0] dec_addrs [7] = '{16'hFAFF, 16'hFB00, 16'hFEDF, 16'hFEE0, 16'hFEFF,
        16'hFF00, 16'hFFFF};
    int bad_count = 0;
    int comparisons = 0;
    int takes = 0;
    ccr_regs #(.NUM_SRC(NSRC)) ccr_regs_i (
        .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .op, .op_len, .op_target, .op_src, .op_bank,
        .alu_result, .alu_carry, .alu_half_carry, .alu_flag_mask, .alu_carry_we,
        .stack_rdata, .irq_req, .irq_low_prio, .irq_take, .irq_sel, .gpr_addr, .gpr_we,
        .gpr_wdata, .gpr_pair, .gpr_wdata16, .gpr_rdata, .data_addr, .data_is_bank,
        .data_is_sfr, .data_stack_ok, .fetch_fault, .pmem_addr, .pmem_rdata,
        .program_counter, .program_status_word, .stack_pointer, .stack_we, .stack_wdata,
        .stack_addr, .boot_ready
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Low bytes follow the address and high bytes are fixed, so every vector is predictable
    always @(posedge clk) begin
        pmem_rdata <= pmem_addr[0] ? 8'h12 : pmem_addr[7:0] + 8'h30;
        if (irq_take === 1'b1) begin
            takes <= takes + 1;
            seen_sel <= irq_sel;
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until waitrequest is seen low; read data taken at that edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic run(input ccr_op_type o);
        op <= o;
        @(posedge clk);
        op <= CCR_OP_NONE;
        @(posedge clk);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #50us;
        bad_count++;
        $display("ERROR watchdog expected finish seen timeout");
        end_sim;
    end
    initial begin
        {arst_n, avs_read, avs_write, alu_carry, alu_half_carry, alu_carry_we} = '0;
        {gpr_we, gpr_pair, avs_address, avs_writedata, op_len, gpr_addr, op_target} = '0;
        {gpr_wdata16, data_addr, op_src, op_bank, alu_result, stack_rdata, gpr_wdata} = '0;
        {irq_req, irq_low_prio} = '0;
        avs_byteenable = 4'hF;
        alu_flag_mask = 2'h3;
        op = CCR_OP_NONE;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 10 && boot_ready !== 1'b1; i++) @(posedge clk);
        @(posedge clk);
        chk("boot pc", program_counter, 16'h1230);
        chk("boot psw", program_status_word, PSW_RESET);
        bus(1'b0, REG_PSW, 32'h0, rd);
        chk("bus psw", rd[7:0], PSW_RESET);
        bus(1'b0, 6'h1C, 32'h0, rd);
        chk("unmapped", rd, UNMAPPED);
        done("reset");
        op_len <= 3'h3;
        run(CCR_OP_STEP);
        chk("step", program_counter, 16'h1233);
        op_target <= 16'hFEE4;
        run(CCR_OP_BRANCH);
        chk("fault", fetch_fault, 1'b1);
        op_target <= 16'h0800;
        run(CCR_OP_BRANCH);
        chk("branch", program_counter, 16'h0800);
        chk("no fault", fetch_fault, 1'b0);
        done("counter");
        // Low priority is allowed here because the priority flag resets to one
        irq_req <= 29'h8;
        irq_low_prio <= 29'h8;
        repeat (6) @(posedge clk);
        chk("masked", takes, 0);
        run(CCR_OP_EI);
        for (int i = 0; i < 20 && takes == 0; i++) @(posedge clk);
        irq_req <= '0;
        chk("irq sel", seen_sel, 5'h03);
        chk("ie cleared", program_status_word[7], 1'b0);
        for (int i = 0; i < 20 && program_counter !== 16'h123A; i++) @(posedge clk);
        chk("irq vector", program_counter, 16'h123A);
        done("interrupt");
        for (int b = 0; b < 4; b++) begin
            op_bank <= b[1:0];
            run(CCR_OP_SELRB);
            chk("bank", {program_status_word[5], program_status_word[3]}, b[1:0]);
        end
        gpr_we <= 1'b1;
        gpr_wdata <= 8'h5A;
        @(posedge clk);
        gpr_addr <= 3'h1;
        gpr_wdata <= 8'hC3;
        @(posedge clk);
        {gpr_we, gpr_addr, gpr_pair} <= {1'b0, 3'h0, 1'b1};
        @(posedge clk);
        chk("pair", gpr_rdata, 16'hC35A);
        alu_carry_we <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            alu_result <= (k == 0) ? 8'h00 : 8'h05;
            {alu_carry, alu_half_carry} <= (k == 0) ? 2'b11 : 2'b00;
            run(CCR_OP_ALU);
            chk("zero", program_status_word[6], k == 0);
            chk("half carry", program_status_word[4], k == 0);
            chk("carry", program_status_word[0], k == 0);
        end
        alu_carry_we <= 1'b0;
        done("flags");
        bus(1'b1, REG_SP, 32'h0000FE20, rd);
        bus(1'b0, REG_SP, 32'h0, rd);
        chk("sp bus", rd[15:0], 16'hFE20);
        bus(1'b1, REG_PSW, 32'h0000002A, rd);
        op <= CCR_OP_PUSHPSW;
        #1;
        chk("push we", stack_we, 1'b1);
        chk("push addr", stack_addr, 16'hFE1F);
        chk("push data", stack_wdata, 8'h2A);
        @(posedge clk);
        op <= CCR_OP_NONE;
        @(posedge clk);
        chk("sp dec", stack_pointer, 16'hFE1F);
        stack_rdata <= 8'h41;
        run(CCR_OP_POPPSW);
        chk("pop psw", program_status_word, 8'h41);
        chk("sp inc", stack_pointer, 16'hFE20);
        run(CCR_OP_EI);
        chk("ei", program_status_word, 8'hC1);
        run(CCR_OP_DI);
        chk("di", program_status_word, 8'h41);
        done("stack");
        foreach (dec_addrs[j]) begin
            data_addr <= dec_addrs[j];
            @(posedge clk);
            chk("bank map", data_is_bank, dec_addrs[j] inside {[16'hFEE0:16'hFEFF]});
            chk("sfr map", data_is_sfr, dec_addrs[j] >= 16'hFF00);
            chk("stack ram", data_stack_ok, dec_addrs[j] inside {[16'hFB00:16'hFEFF]});
        end
        done("decode");
        end_sim;
    end
endmodule
